//--- hw/csdc_pkg.sv
// cycle-steal data channel: shared constants, codes and step type
// assumes both ends and the bench import this package
package csdc_pkg;
  // *****************
  // sizes
  // *****************
  localparam int NLEV = 15;             // steal levels sharing the controls
  localparam int AW   = 16;             // storage address width
  localparam int DW   = 16;             // storage word width
  localparam int LW   = 4;              // level number width
  localparam int STEP_DIV = 1;          // clk cycles per steal-clock step
  // *****************
  // control line codes (line 0 is bit 2)
  // *****************
  localparam logic [2:0] CTL_OUT = 3'h0; // storage word to device
  localparam logic [2:0] CTL_IN  = 3'h1; // device word to storage
  localparam logic [2:0] CTL_LDB = 3'h2; // storage word into address reg
  localparam logic [2:0] CTL_LDI = 3'h3; // device word into address reg
  localparam logic [2:0] CTL_CHK = 3'h6; // address check
  // *****************
  // word count word layout
  // *****************
  localparam int WC_MSB   = 13;
  localparam int SCAN_LSB = 14;
  localparam int SCAN_MSB = 15;
  localparam logic [1:0] SCAN_CONT = 2'h2; // continuous scan code
  localparam logic [1:0] SCAN_RST  = 2'h0;
  localparam logic [AW-1:0] ADDR_RST = 16'h0000;
  typedef enum logic [3:0] {
    CS_IDLE, CS_X7, CS_X0, CS_X1, CS_X2, CS_X3, CS_X4, CS_X5, CS_X6
  } csdc_step_t;
endpackage

//--- hw/csdc_if.sv
// cycle-steal link between the channel controls and the adapters
// assumes each adapter drives only its own element of the level arrays
`timescale 1ns/1ps
`default_nettype none
interface csdc_if;
  import csdc_pkg::*;
  logic [NLEV-1:0]        req;       // steal request per level
  logic [NLEV-1:0]        ack;       // steal acknowledge per level
  logic [NLEV-1:0][2:0]   ctl;       // control lines 0..2 per level
  logic [NLEV-1:0][DW-1:0] din;      // in bus per level
  logic [DW-1:0]          dout;      // out bus
  logic                   done;      // end of steal cycle pulse
  logic                   chk;       // address check failure pulse
  logic [NLEV-1:0]        init;      // initialize pulse per level
  logic                   init_read; // initialize read (device to storage)
  modport chan (input req, ctl, din, output ack, dout, done, chk, init, init_read);
  modport adpt (output req, ctl, din, input ack, dout, done, chk, init, init_read);
endinterface
`default_nettype wire

//--- hw/csdc_chan.sv
// cycle-steal channel controls: priority, address registers, steal clock
// assumes one-cycle storage read latency and a processor that stops at
// its clock 7 while cpu_run is low
`timescale 1ns/1ps
`default_nettype none
module csdc_chan
  import csdc_pkg::*;
#(
  parameter int NL  = csdc_pkg::NLEV,
  parameter int DIV = csdc_pkg::STEP_DIV
)(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   cpu_t6,       // processor at end of T6
  output logic                        cpu_run,      // processor clock may run
  input  wire logic                   io_init,      // initialize command pulse
  input  wire logic [csdc_pkg::LW-1:0] io_init_level,
  input  wire logic [csdc_pkg::AW-1:0] io_init_addr,
  input  wire logic                   io_init_read,
  output logic [csdc_pkg::AW-1:0]     mem_addr,
  output logic                        mem_rd,
  output logic                        mem_we,
  output logic [csdc_pkg::DW-1:0]     mem_wdata,
  input  wire logic [csdc_pkg::DW-1:0] mem_rdata,
  output logic                        addr_chk,     // check failure pulse
  csdc_if.chan                        lnk
);
  import csdc_pkg::*;

  // *****************
  // helpers
  // *****************
  function automatic logic is_load(input logic [2:0] c);
    is_load = (c[2:1] == 2'b01);
  endfunction

  function automatic logic rd_store(input logic [2:0] c);
    rd_store = (c != CTL_IN) && (c != CTL_LDI);
  endfunction

  function automatic logic [LW-1:0] top_lvl(input logic [NL-1:0] v);
    top_lvl = '0;
    for (int i = NL - 1; i >= 0; i--)
    begin
      if (v[i])
        top_lvl = LW'(i);
    end
  endfunction

  // *****************
  // state
  // *****************
  csdc_step_t              st_q;
  logic [NL-1:0]           armed_q;
  logic [NL-1:0]           pri_q;
  logic [NL-1:0][AW-1:0]   car_q;
  logic [AW-1:0]           cab_q;
  logic [DW-1:0]           sbr_q;
  logic [2:0]              ctl_q;
  logic [LW-1:0]           lvl_q;
  logic [NL-1:0]           ack_q;
  logic [DW-1:0]           dout_q;
  logic                    done_q;
  logic                    chk_q;
  logic [NL-1:0]           init_q;
  logic                    init_rd_q;
  logic                    run_q;
  logic                    rd_q;
  logic                    we_q;
  logic [AW-1:0]           addr_q;
  logic [$clog2(DIV+1)-1:0] div_q;
  logic                    step;
  logic [NL-1:0]           want;

  assign step = (div_q == '0);
  assign want = lnk.req & armed_q;  // unarmed levels are never granted

  // steal clock step enable from a divider
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div_q <= '0;
    else if (step)
      div_q <= ($clog2(DIV+1))'(DIV - 1);
    else
      div_q <= div_q - 1'b1;
  end

  // *****************
  // steal sequencer
  // *****************
  // idle waits for the processor's T6; X6 rescans for back-to-back steals
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q  <= CS_IDLE;
      pri_q <= '0;
      lvl_q <= '0;
      run_q <= 1'b1;
    end
    else if (st_q == CS_IDLE)
    begin
      if (cpu_t6 && (|want))
      begin
        pri_q <= want;
        lvl_q <= top_lvl(want);
        run_q <= 1'b0;
        st_q  <= CS_X7;
      end
    end
    else if (step)
    begin
      unique case (st_q)
        CS_X7: st_q <= CS_X0;
        CS_X0: st_q <= CS_X1;
        CS_X1: st_q <= CS_X2;
        CS_X2: st_q <= CS_X3;
        CS_X3: st_q <= CS_X4;
        CS_X4: st_q <= CS_X5;
        CS_X5: st_q <= CS_X6;
        CS_X6:
        begin
          pri_q <= want;
          if (|want)
          begin
            lvl_q <= top_lvl(want);
            st_q  <= CS_X7;
          end
          else
          begin
            run_q <= 1'b1;
            st_q  <= CS_IDLE;
          end
        end
        default: st_q <= CS_IDLE;
      endcase
    end
  end

  // grant only the highest level; lower ones see no acknowledge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_q <= '0;
      ctl_q <= CTL_OUT;
    end
    else if (step && st_q == CS_X7)
    begin
      ack_q <= pri_q & (NL'(1) << lvl_q);
      ctl_q <= lnk.ctl[lvl_q];
    end
    else if (step && st_q == CS_X6)
      ack_q <= '0;
  end

  // *****************
  // address registers and buffer
  // *****************
  // init loads the start address; steals clear, load or count it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      car_q   <= {NL{ADDR_RST}};
      armed_q <= '0;
    end
    else if (io_init)
    begin
      car_q[io_init_level]   <= io_init_addr;
      armed_q[io_init_level] <= 1'b1;
    end
    else if (step && st_q == CS_X3 && is_load(ctl_q))
      car_q[lvl_q] <= ADDR_RST;
    else if (step && st_q == CS_X4)
    begin
      if (is_load(ctl_q))
        car_q[lvl_q] <= sbr_q;
      else
        car_q[lvl_q] <= car_q[lvl_q] + 1'b1;
    end
  end

  // buffer holds the storage address so the register may count meanwhile
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cab_q <= ADDR_RST;
    else if (step && st_q == CS_X7)
      cab_q <= ADDR_RST;
    else if (step && st_q == CS_X1)
      cab_q <= car_q[lvl_q];
  end

  // storage address: register at 7, 0, 1, then frozen like the buffer
  // so the address stays put while the register counts at X4
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      addr_q <= ADDR_RST;
    else if (step && (st_q == CS_X7 || st_q == CS_X0))
      addr_q <= car_q[lvl_q];
    else if (step && st_q == CS_X1)
      addr_q <= car_q[lvl_q];
  end

  // *****************
  // data movement
  // *****************
  // the buffer register holds each word of the steal path; dout_q copies it at X5
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sbr_q <= '0;
    else if (step && st_q == CS_X2)
      sbr_q <= rd_store(ctl_q) ? mem_rdata : lnk.din[lvl_q];
  end

  // one-clock strobes, so a slow step still reads and writes once
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_q   <= 1'b0;
      we_q   <= 1'b0;
      done_q <= 1'b0;
      chk_q  <= 1'b0;
      dout_q <= '0;
    end
    else
    begin
      rd_q   <= step && st_q == CS_X0 && rd_store(ctl_q);
      we_q   <= step && st_q == CS_X5 && ctl_q == CTL_IN;
      done_q <= step && st_q == CS_X5;
      chk_q  <= step && st_q == CS_X5 && ctl_q == CTL_CHK
                && sbr_q != cab_q;
      if (step && st_q == CS_X5)
        dout_q <= sbr_q;
    end
  end

  // initialize is passed on to the adapter of that level
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      init_q    <= '0;
      init_rd_q <= 1'b0;
    end
    else
    begin
      init_q <= io_init ? (NL'(1) << io_init_level) : '0;
      if (io_init)
        init_rd_q <= io_init_read;
    end
  end

  // *****************
  // outputs
  // *****************
  assign cpu_run       = run_q;
  assign mem_addr      = addr_q;       // same value as the buffer from X2 on
  assign mem_rd        = rd_q;
  assign mem_we        = we_q;
  assign mem_wdata     = sbr_q;
  assign addr_chk      = chk_q;
  assign lnk.ack       = ack_q;
  assign lnk.dout      = dout_q;
  assign lnk.done      = done_q;
  assign lnk.chk       = chk_q;
  assign lnk.init      = init_q;
  assign lnk.init_read = init_rd_q;
endmodule
`default_nettype wire

//--- hw/csdc_adpt.sv
// device adapter end of one steal level: word count, scan control, chaining
// assumes the channel controls on the other side of csdc_if
`timescale 1ns/1ps
`default_nettype none
module csdc_adpt
  import csdc_pkg::*;
#(
  parameter int LEVEL = 0,
  parameter bit CHAIN = 1'b1
)(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic                   dev_want,   // device ready for a word
  input  wire logic [csdc_pkg::DW-1:0] dev_wdata, // word for storage
  input  wire logic                   dev_last,   // device ends message
  output logic [csdc_pkg::DW-1:0]     dev_rdata,  // word from storage
  output logic                        dev_rvalid, // pulse with dev_rdata
  output logic                        busy,
  output logic                        err,        // address check failure seen
  csdc_if.adpt                        lnk
);
  import csdc_pkg::*;

  typedef enum logic [2:0] {
    CA_OFF, CA_WC, CA_DATA, CA_LOAD, CA_CHK, CA_CWC
  } csdc_adst_t;

  csdc_adst_t          st_q;
  logic                req_q;
  logic                pend_q;
  logic                rdir_q;
  logic [WC_MSB:0]     wc_q;
  logic [1:0]          scan_q;
  logic [2:0]          ctl_q;
  logic [DW-1:0]       din_q;
  logic [DW-1:0]       rdata_q;
  logic                rvalid_q;
  logic                err_q;
  logic                fin;
  logic                ask;

  assign fin = lnk.done && lnk.ack[LEVEL];
  assign ask = (st_q != CA_OFF) && !pend_q && (st_q != CA_DATA || dev_want);

  // *****************
  // request handshake
  // *****************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_q  <= 1'b0;
      pend_q <= 1'b0;
      ctl_q  <= CTL_OUT;
      din_q  <= '0;
    end
    else if (lnk.init[LEVEL])
    begin
      req_q  <= 1'b0;
      pend_q <= 1'b0;
    end
    else if (ask)
    begin
      req_q  <= 1'b1;
      pend_q <= 1'b1;
      din_q  <= dev_wdata;
      unique case (st_q)
        CA_DATA: ctl_q <= rdir_q ? CTL_IN : CTL_OUT;
        CA_LOAD: ctl_q <= CTL_LDB;
        CA_CHK:  ctl_q <= CTL_CHK;
        default: ctl_q <= CTL_OUT;
      endcase
    end
    else
    begin
      if (lnk.ack[LEVEL])
        req_q <= 1'b0;
      if (fin)
        pend_q <= 1'b0;
    end
  end

  // *****************
  // transfer sequence
  // *****************
  // a finished table either chains three steals or stops for good
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q   <= CA_OFF;
      rdir_q <= 1'b0;
      wc_q   <= '0;
      scan_q <= SCAN_RST;
      err_q  <= 1'b0;
    end
    else if (lnk.init[LEVEL])
    begin
      st_q   <= CA_WC;
      rdir_q <= lnk.init_read;
      err_q  <= 1'b0;
    end
    else if (fin)
    begin
      unique case (st_q)
        CA_WC, CA_CWC:
        begin
          wc_q   <= lnk.dout[WC_MSB:0];
          scan_q <= lnk.dout[SCAN_MSB:SCAN_LSB];
          st_q   <= (lnk.dout[WC_MSB:0] == '0) ? CA_OFF : CA_DATA;
        end
        CA_DATA:
        begin
          wc_q <= wc_q - 1'b1;
          if (wc_q == (WC_MSB+1)'(1) || dev_last)
            st_q <= (CHAIN && scan_q == SCAN_CONT) ? CA_LOAD : CA_OFF;
        end
        CA_LOAD: st_q <= CA_CHK;
        CA_CHK:
        begin
          err_q <= err_q | lnk.chk;
          st_q  <= CA_CWC;
        end
        default: st_q <= CA_OFF;
      endcase
    end
  end

  // storage words handed to the device on write transfers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= fin && st_q == CA_DATA && !rdir_q;
      if (fin && st_q == CA_DATA && !rdir_q)
        rdata_q <= lnk.dout;
    end
  end

  // *****************
  // outputs
  // *****************
  assign lnk.req[LEVEL] = req_q;
  assign lnk.ctl[LEVEL] = ctl_q;
  assign lnk.din[LEVEL] = din_q;
  assign dev_rdata      = rdata_q;
  assign dev_rvalid     = rvalid_q;
  assign busy           = pend_q;
  assign err            = err_q;
endmodule
`default_nettype wire

//--- dv/csdc_link_assertions.sv
// link checker: acknowledge, done and check pulse timing on the steal link
// assumes the bench feeds it the link signals by name, one clock domain
`timescale 1ns/1ps
`default_nettype none
module csdc_link_chk (
  input wire logic                           clk,
  input wire logic                           rstn,
  input wire logic [csdc_pkg::NLEV-1:0]      req,
  input wire logic [csdc_pkg::NLEV-1:0]      ack,
  input wire logic [csdc_pkg::NLEV-1:0][2:0] ctl,
  input wire logic                           done,
  input wire logic                           chk,
  input wire logic [csdc_pkg::NLEV-1:0]      init
);
  import csdc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // levels whose control lines ask for an address check
  logic [NLEV-1:0] chk_code;
  always_comb
  begin
    chk_code = '0;
    for (int i = 0; i < NLEV; i++)
      chk_code[i] = (ctl[i] == CTL_CHK);
  end
  // **********************
  // steal cycle framing
  // **********************
  // one level at a time, since all levels share one address path
  ack_one_hot_a: assert property ($onehot0(ack))
    else $error("more than one level acknowledged");
  ack_has_req_a: assert property ($rose(|ack) |-> |(ack & req))
    else $error("acknowledge without a request");
  ack_holds_a: assert property ($rose(|ack) |=> ($stable(ack)) [*6])
    else $error("acknowledge changed inside a steal cycle");
  done_at_x6_a: assert property ($rose(|ack) |-> ##6 (done && |ack))
    else $error("steal cycle not closed at its sixth step");
  done_pulse_a: assert property (done |=> !done)
    else $error("done wider than one clock");
  ack_release_a: assert property ((done && |ack) |=> ack == '0)
    else $error("acknowledge kept after done");
  ack_end_a: assert property ($fell(|ack) |-> $past(done))
    else $error("steal cycle ended without done");
  chk_in_done_a: assert property (chk |-> done && |ack)
    else $error("address check outside a steal cycle end");
  chk_by_code_a: assert property (chk |-> |(ack & chk_code))
    else $error("address check on a level not asking for one");
  init_pulse_a: assert property (|init |=> init == '0)
    else $error("initialize wider than one clock");
  // main scenarios reached
  cover property (chk);
  cover property ($rose(ack[0]));
  cover property ($rose(ack[1]));
endmodule
`default_nettype wire

//--- dv/cycle_steal_data_channel_bench.sv
// bench: channel controls and two adapters joined by the link interface
// assumes a processor stub pulsing cpu_t6 and a 256-word storage model
`timescale 1ns/1ps
`default_nettype none
module cycle_steal_data_channel_bench;
  import csdc_pkg::*;
  logic             clk = 1'b0;
  logic             rstn = 1'b0;
  logic             cpu_t6 = 1'b0;
  logic             cpu_run;
  logic             io_init = 1'b0;
  logic [3:0]       io_lvl = 4'h0;
  logic [15:0]      io_addr = 16'h0000;
  logic             io_rd = 1'b0;
  logic [15:0]      mem_addr, mem_wdata;
  logic [15:0]      mem_rdata = 16'h0000;
  logic             mem_rd, mem_we, addr_chk;
  logic [1:0]       want = 2'b00;
  logic [1:0]       dlast = 2'b00;
  logic             req14 = 1'b0;
  logic [1:0][15:0] wdata = '0;
  logic [1:0][15:0] rdata;
  logic [1:0]       rv, busy, err;
  logic [2:0]       t6_cnt = 3'h0;
  logic [15:0]      mem [0:255];
  logic [15:0]      rd_log[$], ack_log[$], rq0[$], rq1[$];
  logic [14:0]      ack_prev = '0;
  int               err_count = 0;
  int               n_checks = 0;
  int               chk_seen = 0;
  int               cyc = 0;
  always #12.5 clk = ~clk;
  csdc_if csdc_if_i ();
  // levels 2 to 13, which have no adapter, stay quiet
  // level 14 may request although it is never initialized
  assign csdc_if_i.req[14:2] = {req14, 12'h000};
  assign csdc_if_i.ctl[14:2] = '0;
  assign csdc_if_i.din[14:2] = '0;
  csdc_chan csdc_chan_i (
    .clk(clk), .rstn(rstn), .cpu_t6(cpu_t6), .cpu_run(cpu_run), .io_init(io_init),
    .io_init_level(io_lvl), .io_init_addr(io_addr), .io_init_read(io_rd),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .addr_chk(addr_chk), .lnk(csdc_if_i));
  // level 0 chains, level 1 does not
  for (genvar g = 0; g < 2; g++)
  begin : g_ad
    csdc_adpt #(.LEVEL(g), .CHAIN(g == 0)) csdc_adpt_i (
      .clk(clk), .rstn(rstn), .dev_want(want[g]), .dev_wdata(wdata[g]), .dev_last(dlast[g]),
      .dev_rdata(rdata[g]), .dev_rvalid(rv[g]), .busy(busy[g]), .err(err[g]),
      .lnk(csdc_if_i));
  end
  csdc_link_chk csdc_link_chk_i (
    .clk(clk), .rstn(rstn), .req(csdc_if_i.req), .ack(csdc_if_i.ack), .ctl(csdc_if_i.ctl),
    .done(csdc_if_i.done), .chk(csdc_if_i.chk), .init(csdc_if_i.init));
  // **********************
  // processor stub, storage and monitors
  // **********************
  // everything off the falling edge so sampling never races the design
  always @(negedge clk)
  begin
    t6_cnt = cpu_run ? t6_cnt + 3'h1 : t6_cnt;
    cpu_t6 = cpu_run && (t6_cnt == 3'h6);
    if (mem_rd)
    begin
      mem_rdata = mem[mem_addr[7:0]];
      rd_log.push_back(mem_addr);
    end
    if (mem_we) mem[mem_addr[7:0]] = mem_wdata;
    if (rv[0]) rq0.push_back(rdata[0]);
    if (rv[1]) rq1.push_back(rdata[1]);
    if (addr_chk) chk_seen++;
    if ((csdc_if_i.ack != '0) && (ack_prev == '0))
    begin
      ack_log.push_back(csdc_if_i.ack[0] ? 16'h0000 : 16'h0001);
      chk({15'h0, cpu_run}, 16'h0000);
    end
    ack_prev = csdc_if_i.ack;
  end
  // hang guard, well above the several hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  // **********************
  // shared tasks
  // **********************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic start(input logic [3:0] lvl, input logic [15:0] a, input logic rd);
    while (!cpu_run) @(negedge clk);
    io_init = 1'b1;
    io_lvl = lvl;
    io_addr = a;
    io_rd = rd;
    @(negedge clk);
    io_init = 1'b0;
    @(negedge clk);
  endtask
  // busy drops for one clock between steals, so wait for a quiet stretch
  task automatic wait_idle;
    int quiet;
    quiet = 0;
    for (int i = 0; i < 3000 && quiet < 16; i++)
    begin
      @(negedge clk);
      quiet = (busy == 2'b00 && cpu_run) ? quiet + 1 : 0;
    end
    repeat (8) @(negedge clk);
  endtask
  function automatic logic [15:0] in_log(input logic [15:0] a);
    foreach (rd_log[i])
      if (rd_log[i] === a) return 16'h0001;
    return 16'h0000;
  endfunction
  // **********************
  // scenarios
  // **********************
  // requests before any initialize are ignored
  task automatic t_reset;
    chk({15'h0, cpu_run}, 16'h0001);
    want = 2'b11;
    req14 = 1'b1;
    repeat (40) @(negedge clk);
    chk(16'(ack_log.size()), 16'h0000);
    want = 2'b00;
    req14 = 1'b0;
  endtask
  // storage to device, no chaining, count of three
  task automatic t_out;
    mem[8'h20] = 16'h0003;
    for (int i = 1; i < 5; i++) mem[8'h20 + i] = 16'h1111 * i;
    want = 2'b10;
    start(4'h1, 16'h0020, 1'b0);
    wait_idle();
    chk(16'(rq1.size()), 16'h0003);
    foreach (rq1[i]) chk(rq1[i], 16'h1111 * (i + 1));
    chk({15'h0, csdc_if_i.req[1]}, 16'h0000);
    chk(in_log(16'h0024), 16'h0000);
  endtask
  // device to storage, write stops at the count boundary
  task automatic t_in;
    mem[8'h40] = 16'h0002;
    mem[8'h43] = 16'hdead;
    wdata[0] = 16'h5a5a;
    want = 2'b01;
    start(4'h0, 16'h0040, 1'b1);
    wait_idle();
    chk(mem[8'h41], 16'h5a5a);
    chk(mem[8'h42], 16'h5a5a);
    chk(mem[8'h43], 16'hdead);
  endtask
  // continuous scan into a table whose count is zero
  task automatic t_chain(input logic bad);
    mem[8'h60] = 16'h8001;
    mem[8'h61] = 16'hbeef;
    mem[8'h62] = 16'h0080;
    mem[8'h80] = bad ? 16'h0081 : 16'h0080;
    mem[8'h81] = 16'h0000;
    rd_log.delete();
    rq0.delete();
    chk_seen = 0;
    want = 2'b01;
    start(4'h0, 16'h0060, 1'b0);
    wait_idle();
    chk(rq0[0], 16'hbeef);
    chk(in_log(16'h0080), 16'h0001);
    chk(in_log(16'h0081), 16'h0001);
    chk(in_log(16'h0082), 16'h0000);
    chk({15'h0, err[0]}, {15'h0, bad});
    chk(16'(chk_seen), {15'h0, bad});
  endtask
  // both levels pending at one scan: level 0 goes first
  task automatic t_prio;
    mem[8'h20] = 16'h0002;
    mem[8'h40] = 16'h0002;
    ack_log.delete();
    want = 2'b11;
    while (!cpu_t6) @(negedge clk);
    start(4'h1, 16'h0020, 1'b0);
    start(4'h0, 16'h0040, 1'b0);
    wait_idle();
    chk(ack_log[0], 16'h0000);
    chk(16'(ack_log.size()), 16'h0006);
    want = 2'b00;
  endtask
  // device indicator ends the message before the count runs out
  task automatic t_last;
    mem[8'ha0] = 16'h0005;
    mem[8'ha1] = 16'h7777;
    rq1.delete();
    rd_log.delete();
    dlast = 2'b10;
    want = 2'b10;
    start(4'h1, 16'h00a0, 1'b0);
    wait_idle();
    chk(16'(rq1.size()), 16'h0001);
    chk(rq1[0], 16'h7777);
    chk(in_log(16'h00a2), 16'h0000);
    dlast = 2'b00;
    want = 2'b00;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset();
    t_out();
    t_in();
    t_chain(1'b0);
    t_chain(1'b1);
    t_prio();
    t_last();
    end_sim();
  end
endmodule
`default_nettype wire
